//--- src/port_b_consts.svh
// constants for the system control port and interrupt logic
// Notes on behaviour
// - write to port 70h with data bit 7 low enables the interrupt output.
// - when enabled, channel check low or parity error raises the interrupt.
// - port 61h: bits 3-0 read/write, reset to zero; bits 7-4 read-only.
// - bit 7 parity flag sets only while bit 2 low; writing bit 2 one clears.
// - bit 6 channel flag sets only while bit 3 low; writing bit 3 one clears.
// - bit 5 reads the tone counter output level sampled at the read request edge.
// - bit 4 is a toggle flip-flop flipping on each refresh cycle.
// - bit 3 low lets channel check cause the interrupt; high ignores it.
// - bit 2 low lets parity errors cause the interrupt; high blocks them.
// - speaker output is bit 1 ANDed with the tone counter output.
// - bit 0 drives the tone counter gate input.
`ifndef PORT_B_CONSTS_SVH
`define PORT_B_CONSTS_SVH
`define ADDR_NMI_CTRL   16'h0070
`define ADDR_SYS_PORT   16'h0061
`define BIT_NMI_DIS     7
`define BIT_PARITY      7
`define BIT_CHAN        6
`define BIT_TONE_OUT    5
`define BIT_REFRESH     4
`define BIT_CHAN_MASK   3
`define BIT_PAR_MASK    2
`define BIT_SPK_DATA    1
`define BIT_TONE_GATE   0
`define CTRL_RESET      4'h0
`define CTRL_MSB        3
`define RDATA_RESET     8'h00
`endif

//--- src/port_b_pkg.sv
// types shared by the system control port logic
package port_b_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } io_req_t;
   typedef struct packed {
      logic flag_parity;
      logic flag_chan;
   } err_flags_t;
endpackage

//--- src/err_flag_cell.sv
// one sticky error flag with mask gating and write-one clear
module err_flag_cell
   import port_b_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic reset_n,
   input  wire logic event_in,
   input  wire logic mask_n,
   input  wire logic clear,
   output logic      flag
);
   logic flag_r;
   logic flag_nxt;

   always_comb
   begin
      flag_nxt = flag_r;
      if (clear)
         flag_nxt = 1'b0;
      // set only while unmasked; set beats clear
      if (event_in && !mask_n)
         flag_nxt = 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         flag_r <= 1'b0;
      else
         flag_r <= flag_nxt;
   end

   assign flag = flag_r;
endmodule

//--- src/system_port_b_nmi_logic.sv
// system control port register and non-maskable interrupt logic
`include "port_b_consts.svh"
module system_port_b_nmi_logic
   import port_b_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire io_req_t     io_req,
   output logic [7:0]       io_rdata,
   output logic             io_rvalid,
   input  wire logic        io_channel_error_n,
   input  wire logic        ram_parity_error,
   input  wire logic        refresh_pulse,
   input  wire logic        tone_counter_output,
   output logic             tone_counter_gate,
   output logic             speaker_out,
   output logic             nmi_out
);
   // ----------------------------------------
   // register state
   // ----------------------------------------
   logic [3:0] ctrl_r;
   logic [3:0] ctrl_nxt;
   logic       nmi_en_r;
   logic       nmi_en_nxt;
   logic       refresh_toggle_r;
   logic       refresh_toggle_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       rvalid_r;
   logic       rvalid_nxt;
   logic       nmi_r;
   logic       nmi_nxt;
   err_flags_t flags;
   logic       wr_port;
   logic       wr_nmi;
   logic       parity_mask_n;
   logic       chan_error_mask_n;
   logic       speaker_data_gate;
   logic       rd_port;
   logic       clr_parity;
   logic       clr_chan;

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   // full 16-bit compare; an alias decode would let stray ports touch the mask bits
   function automatic logic addr_hit
   (
      input io_req_t     req,
      input logic [15:0] addr
   );
      return req.addr == addr;
   endfunction

   // write-one clear of a flag through its own mask bit in the same write
   function automatic logic mask_clear
   (
      input io_req_t req,
      input int      pos
   );
      return req.wr && addr_hit(req, `ADDR_SYS_PORT) && req.wdata[pos];
   endfunction

   // status byte as the port returns it; upper nibble is never stored
   function automatic logic [7:0] status_byte
   (
      input err_flags_t fl,
      input logic       tone,
      input logic       refresh,
      input logic [3:0] ctrl
   );
      logic [7:0] b;
      b                = {4'h0, ctrl};
      b[`BIT_PARITY]   = fl.flag_parity;
      b[`BIT_CHAN]     = fl.flag_chan;
      b[`BIT_TONE_OUT] = tone;
      b[`BIT_REFRESH]  = refresh;
      return b;
   endfunction

   assign wr_port           = io_req.wr && addr_hit(io_req, `ADDR_SYS_PORT);
   assign wr_nmi            = io_req.wr && addr_hit(io_req, `ADDR_NMI_CTRL);
   assign rd_port           = io_req.rd && addr_hit(io_req, `ADDR_SYS_PORT);
   assign clr_parity        = mask_clear(io_req, `BIT_PAR_MASK);
   assign clr_chan          = mask_clear(io_req, `BIT_CHAN_MASK);
   assign chan_error_mask_n = ctrl_r[`BIT_CHAN_MASK];
   assign parity_mask_n     = ctrl_r[`BIT_PAR_MASK];
   assign speaker_data_gate = ctrl_r[`BIT_SPK_DATA];

   // ----------------------------------------
   // control register group
   // ----------------------------------------
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      if (wr_port)
         ctrl_nxt = io_req.wdata[`CTRL_MSB:0];
   end

   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         ctrl_r <= `CTRL_RESET;
      else
         ctrl_r <= ctrl_nxt;
   end

   // ----------------------------------------
   // interrupt enable and output group
   // ----------------------------------------
   always_comb
   begin
      nmi_en_nxt = nmi_en_r;
      // disable on bit 7 high, enable on bit 7 low, held otherwise
      if (wr_nmi)
         nmi_en_nxt = !io_req.wdata[`BIT_NMI_DIS];
      // nmi from either latched source
      // registered so a flag and its clear never glitch the pin
      nmi_nxt = nmi_en_r && (flags.flag_parity || flags.flag_chan);
   end

   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         nmi_en_r <= 1'b0;
         nmi_r    <= 1'b0;
      end
      else
      begin
         nmi_en_r <= nmi_en_nxt;
         nmi_r    <= nmi_nxt;
      end
   end

   // ----------------------------------------
   // refresh toggle group
   // ----------------------------------------
   always_comb
   begin
      refresh_toggle_nxt = refresh_toggle_r;
      if (refresh_pulse)
         refresh_toggle_nxt = !refresh_toggle_r;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         refresh_toggle_r <= 1'b0;
      else
         refresh_toggle_r <= refresh_toggle_nxt;
   end

   // ----------------------------------------
   // read port group
   // ----------------------------------------
   always_comb
   begin
      rdata_nxt  = rdata_r;
      rvalid_nxt = 1'b0;
      // read-back, upper nibble status only
      // tone level is taken at the request edge, one cycle old when shown
      if (rd_port)
      begin
         rvalid_nxt = 1'b1;
         rdata_nxt  = status_byte(flags, tone_counter_output, refresh_toggle_r, ctrl_r);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         rdata_r  <= `RDATA_RESET;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // ----------------------------------------
   // error flags
   // ----------------------------------------
   // parity flag gated by mask, write-one clear
   err_flag_cell u_parity
   (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .event_in (ram_parity_error),
      .mask_n   (parity_mask_n),
      .clear    (clr_parity),
      .flag     (flags.flag_parity)
   );

   // channel flag gated by mask, write-one clear
   // channel mask ignores input when high
   err_flag_cell u_chan
   (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .event_in (!io_channel_error_n),
      .mask_n   (chan_error_mask_n),
      .clear    (clr_chan),
      .flag     (flags.flag_chan)
   );

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign io_rdata  = rdata_r;
   assign io_rvalid = rvalid_r;
   assign nmi_out   = nmi_r;
   assign tone_counter_gate = ctrl_r[`BIT_TONE_GATE];
   // speaker and-gate; combinational so the tone is not delayed
   assign speaker_out = speaker_data_gate && tone_counter_output;
endmodule

//--- sim/port_b_sva.sv
// checker on the control port pins
module port_b_sva
   import port_b_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       reset_n,
   input wire io_req_t    io_req,
   input wire logic [7:0] io_rdata,
   input wire logic       io_rvalid,
   input wire logic       tone_counter_output,
   input wire logic       tone_counter_gate,
   input wire logic       speaker_out,
   input wire logic       nmi_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire rd61 = io_req.rd && io_req.addr == 16'h0061;
   wire wr61 = io_req.wr && io_req.addr == 16'h0061;
   wire wr70 = io_req.wr && io_req.addr == 16'h0070;
   rd_answer_a: assert property (rd61 |=> io_rvalid)
      else $error("read unanswered");
   answer_cause_a: assert property (io_rvalid |-> $past(rd61))
      else $error("stray answer");
   rdata_hold_a: assert property (!io_rvalid |-> $stable(io_rdata))
      else $error("read data moved");
   tone_read_a: assert property (io_rvalid |-> io_rdata[5] == $past(tone_counter_output))
      else $error("tone bit wrong");
   gate_wr_a: assert property (wr61 ##1 !wr61 |=> tone_counter_gate == $past(io_req.wdata[0], 2))
      else $error("gate wrong");
   spk_and_a: assert property (speaker_out |-> tone_counter_output)
      else $error("speaker without tone");
   spk_low_a: assert property (wr61 && !io_req.wdata[1] ##1 !wr61 |=> !speaker_out)
      else $error("speaker not held low");
   nmi_dis_a: assert property (wr70 && io_req.wdata[7] ##1 !wr70 |=> !nmi_out)
      else $error("interrupt not disabled");
   cover property (io_rvalid && io_rdata[7]);
   cover property ($rose(nmi_out));
   cover property (speaker_out);
endmodule
bind system_port_b_nmi_logic port_b_sva chk (.*);

//--- sim/tone_timer_model.sv
// stand-in for timer counter 2 beside the port
module tone_timer_model
(
   input  wire logic clk_sys,
   input  wire logic gate,
   output logic      tone
);
   timeunit 1ns;
   timeprecision 1ps;
   // gate starts counter
   // level follows gate a clock late; no square wave, so reads stay predictable
   always_ff @(posedge clk_sys) tone <= gate;
endmodule

//--- sim/tb_top.sv
// testbench for the control port and interrupt logic
`define CHK(g,e) begin cmp_count++; if ((g)!==(e)) begin mismatches++; $display("MISMATCH t=%0t got=%h exp=%h",$time,g,e); end end
module tb_top
   import port_b_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_sys = 0, reset_n = 0, chan_n = 1, par = 0, refr = 0;
   io_req_t    rq = '0;
   logic [7:0] rdata;
   logic       rvalid, tone, gate, spk, nmi;
   int         mismatches = 0, cmp_count = 0;
   always #2 clk_sys = ~clk_sys;
   system_port_b_nmi_logic dut (.clk_sys(clk_sys), .reset_n(reset_n), .io_req(rq), .io_rdata(rdata),
      .io_rvalid(rvalid), .io_channel_error_n(chan_n), .ram_parity_error(par), .refresh_pulse(refr),
      .tone_counter_output(tone), .tone_counter_gate(gate), .speaker_out(spk), .nmi_out(nmi));
   tone_timer_model tmr (.clk_sys(clk_sys), .gate(gate), .tone(tone));
   task automatic cyc(int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic wr(logic [15:0] a, logic [7:0] d);
      rq = '{1'b1, 1'b0, a, d};
      cyc(1);
      rq = '0;
      cyc(1);
   endtask
   // answer comes one clock after the request edge
   task automatic rd(logic [15:0] a, logic [7:0] e);
      rq = '{1'b0, 1'b1, a, 8'h00};
      cyc(1);
      `CHK(rvalid, a == 16'h0061)
      if (a == 16'h0061) `CHK(rdata, e)
      rq = '0;
      cyc(1);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      cyc(3);
      reset_n = 1;
      rd(16'h0061, 8'h00);
      rd(16'h0062, 8'h00);
      rd(16'h0070, 8'h00);
      wr(16'h0061, 8'hF3);
      cyc(2);
      rd(16'h0061, 8'h23);
      `CHK({gate, spk}, 2'b11)
      refr = 1;
      cyc(1);
      refr = 0;
      rd(16'h0061, 8'h33);
      wr(16'h0061, 8'h01);
      `CHK(spk, 1'b0)
      wr(16'h0070, 8'h00);
      par = 1;
      cyc(1);
      par = 0;
      cyc(2);
      `CHK(nmi, 1'b1)
      rd(16'h0061, 8'hB1);
      wr(16'h0061, 8'h05);
      `CHK(nmi, 1'b0)
      par = 1;
      cyc(1);
      par = 0;
      rd(16'h0061, 8'h35);
      chan_n = 0;
      cyc(3);
      `CHK(nmi, 1'b1)
      chan_n = 1;
      rd(16'h0061, 8'h75);
      wr(16'h0061, 8'h0D);
      chan_n = 0;
      cyc(3);
      rd(16'h0061, 8'h3D);
      `CHK(nmi, 1'b0)
      wr(16'h0061, 8'h01);
      cyc(2);
      `CHK(nmi, 1'b1)
      wr(16'h0070, 8'h80);
      cyc(4);
      `CHK(nmi, 1'b0)
      test_done();
   end
endmodule
